/* File: rtl/nand_flash_pin_interface.sv */
// Purpose: pin sequencer for nand flash devices and a card slot
// Assumes: one request at a time, read bytes buffered toward the core
// Notes: card mode shares chip select pins one to three
`timescale 1ns/1ps
module nand_flash_pin_interface
    import nand_pins_pkg::*;
(
    input wire logic i_core_clk, // 100 MHz core clock
    input wire logic i_sys_rst, // sync reset, high
    input wire logic [NUM_CS-1:1] i_flash_or_card, // per pin: 1 card use
    input wire logic i_wr_protect_req, // core asks memory protected
    input wire logic i_req_valid, // request offered
    output logic o_req_ready, // request accepted
    input wire req_s i_req, // request contents
    output logic o_rd_valid, // read byte ready
    input wire logic i_rd_ready, // core takes read byte
    output logic [DATA_W-1:0] o_rd_data, // read byte
    output logic o_card_wr_locked, // card write protected
    output logic o_card_inserted, // card in slot
    output logic o_busy, // cycle in progress
    input wire logic [DATA_W-1:0] i_mem_data_bus, // data bus in
    output logic [DATA_W-1:0] o_mem_data_bus, // data bus out
    output logic o_mem_data_bus_oe_n, // low while driving
    output logic o_addr_latch_en, // address latch
    output logic o_cmd_latch_en, // command latch
    output logic o_read_strobe_n, // read strobe
    output logic o_write_strobe_n, // write strobe
    output logic o_chip_sel0_n, // chip select zero
    output logic o_chip_sel1_n, // select one out
    output logic o_chip_sel1_oe_n, // low while driving select one
    input wire logic i_card_wr_lock_n, // shared pin one input
    output logic o_chip_sel2_n, // select two out
    output logic o_chip_sel2_oe_n, // low while driving select two
    input wire logic i_card_present_n, // shared pin two input
    output logic o_card_sel_n, // select three or card select
    output logic o_mem_wr_protect_n // write protect, low in reset
);
    ////////////////////////////////////////////////////////////////////////
    // state and carriers
    typedef enum logic [1:0] {
        S_IDLE,
        S_SETUP,
        S_STROBE,
        S_HOLD
    } ph_e;

    typedef struct packed {
        ph_e ph; // cycle phase
        req_s req; // request in flight
        logic [CNT_W-1:0] cnt; // phase timer
        pins_s pins; // registered pin levels
        logic [DATA_W-1:0] dout; // bus output byte
        logic drive; // bus driven
        logic [DATA_W-1:0] rbyte; // captured read byte
        logic rpush; // push captured byte
        logic wp_n; // write protect level
    } st_s;

    st_s st;
    st_s next_st;
    pins_s idle_pins;
    logic [1:0] lvl; // synchronised shared inputs
    logic buf_ready; // read buffer has room
    logic card_mode3;

    ////////////////////////////////////////////////////////////////////////
    // one-hot active-low select for one target
    function automatic logic [NUM_CS-1:0] sel_n(input logic [1:0] idx);
        logic [NUM_CS-1:0] v;
        v = '1;
        v[idx] = 1'b0;
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // synchronise shared card pins, pulled high when idle
    pin_sync #(.W(2), .INIT(2'h3)) u_sync (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_async({i_card_present_n, i_card_wr_lock_n}),
        .o_sync(lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // read byte buffer toward the core
    skid_buf #(.W(DATA_W), .DEPTH(2)) u_rbuf (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(st.rpush),
        .o_in_ready(buf_ready),
        .i_in_data(st.rbyte),
        .o_out_valid(o_rd_valid),
        .i_out_ready(i_rd_ready),
        .o_out_data(o_rd_data)
    );

    assign card_mode3 = i_flash_or_card[3];
    always_comb begin
        idle_pins = '{addr_latch_en: 1'b0, cmd_latch_en: 1'b0,
                      read_strobe_n: 1'b1, write_strobe_n: 1'b1, chip_sel_n: '1};
    end

    // a read needs buffer room before start so no byte is lost
    assign o_req_ready = (st.ph == S_IDLE) && buf_ready;

    ////////////////////////////////////////////////////////////////////////
    // cycle sequencer
    always_comb begin
        next_st = st;
        next_st.rpush = 1'b0;
        next_st.wp_n = ~i_wr_protect_req;
        unique case (st.ph)
            S_IDLE: begin
                next_st.pins = idle_pins;
                next_st.drive = 1'b0;
                if (i_req_valid && o_req_ready) begin
                    next_st.req = i_req;
                    next_st.ph = S_SETUP;
                    next_st.cnt = CNT_W'(SETUP_CYC - 1);
                    // card access uses pin three, else device number
                    if (i_req.card) begin
                        next_st.pins.chip_sel_n = sel_n(TGT_CARD);
                    end else begin
                        next_st.pins.chip_sel_n = sel_n(i_req.dev);
                    end
                    next_st.pins.addr_latch_en = (i_req.op == OP_ADDR);
                    next_st.pins.cmd_latch_en = (i_req.op == OP_CMD);
                    next_st.drive = (i_req.op != OP_READ);
                    next_st.dout = i_req.data;
                end
            end
            S_SETUP: begin
                if (st.cnt == '0) begin
                    next_st.ph = S_STROBE;
                    next_st.cnt = CNT_W'(STROBE_CYC - 1);
                    if (st.req.op == OP_READ) begin
                        next_st.pins.read_strobe_n = 1'b0;
                    end else begin
                        next_st.pins.write_strobe_n = 1'b0;
                    end
                end else begin
                    next_st.cnt = CNT_W'(st.cnt - 1'b1);
                end
            end
            S_STROBE: begin
                if (st.cnt == '0) begin
                    // sample read data at end of strobe low
                    if (st.req.op == OP_READ) begin
                        next_st.rbyte = i_mem_data_bus;
                        next_st.rpush = 1'b1;
                    end
                    next_st.pins.read_strobe_n = 1'b1;
                    next_st.pins.write_strobe_n = 1'b1;
                    next_st.ph = S_HOLD;
                end else begin
                    next_st.cnt = CNT_W'(st.cnt - 1'b1);
                end
            end
            S_HOLD: begin
                // release latches, select and bus after hold
                next_st.pins = idle_pins;
                next_st.drive = 1'b0;
                next_st.ph = S_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; protect low through reset
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            st <= '0;
            st.ph <= S_IDLE;
            st.pins <= '{1'b0, 1'b0, 1'b1, 1'b1, 4'hf};
            st.wp_n <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin outputs and shared pin direction
    assign o_addr_latch_en = st.pins.addr_latch_en;
    assign o_cmd_latch_en = st.pins.cmd_latch_en;
    assign o_read_strobe_n = st.pins.read_strobe_n;
    assign o_write_strobe_n = st.pins.write_strobe_n;
    assign o_mem_data_bus = st.dout;
    assign o_mem_data_bus_oe_n = ~st.drive;
    assign o_chip_sel0_n = st.pins.chip_sel_n[0];
    assign o_chip_sel1_n = st.pins.chip_sel_n[1];
    assign o_chip_sel1_oe_n = i_flash_or_card[1];
    assign o_chip_sel2_n = st.pins.chip_sel_n[2];
    assign o_chip_sel2_oe_n = i_flash_or_card[2];
    assign o_card_sel_n = st.pins.chip_sel_n[3];
    assign o_mem_wr_protect_n = st.wp_n;
    assign o_busy = (st.ph != S_IDLE);
    // low input means locked or inserted, only in card use
    assign o_card_wr_locked = i_flash_or_card[1] && !lvl[0];
    assign o_card_inserted = i_flash_or_card[2] && !lvl[1];

    ////////////////////////////////////////////////////////////////////////
    // assertions
    a_one_select: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        $countones(~st.pins.chip_sel_n) <= 1)
        else $error("more than one chip select low");
    a_idle_select: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (st.ph == S_IDLE) |-> (st.pins.chip_sel_n == 4'hf))
        else $error("chip select low while idle");
    a_addr_latch: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        o_addr_latch_en |-> (st.req.op == OP_ADDR && st.ph != S_IDLE))
        else $error("address latch high outside address cycle");
    a_cmd_latch: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        o_cmd_latch_en |-> (st.req.op == OP_CMD && st.ph != S_IDLE))
        else $error("command latch high outside command cycle");
    a_read_strobe: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        $fell(o_read_strobe_n) |-> (st.req.op == OP_READ)
        ##0 !o_read_strobe_n [*3] ##1 o_read_strobe_n)
        else $error("read strobe width wrong");
    a_write_strobe: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        $fell(o_write_strobe_n) |-> (!o_mem_data_bus_oe_n && st.req.op != OP_READ)
        ##0 !o_write_strobe_n [*3] ##1 o_write_strobe_n)
        else $error("write strobe width wrong");
    a_bus_read: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !o_read_strobe_n |-> o_mem_data_bus_oe_n)
        else $error("bus driven during read");
    a_dev_select: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_req_valid && o_req_ready && !i_req.card && i_req.dev == 2'h0)
        |=> !o_chip_sel0_n)
        else $error("select zero not low for device zero");
    a_card_select: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_req_valid && o_req_ready && i_req.card) |=> !o_card_sel_n [*2])
        else $error("card select not low for card access");
    a_protect_reset: assert property (@(posedge i_core_clk)
        i_sys_rst |=> !o_mem_wr_protect_n)
        else $error("write protect not low after reset");
    a_card_lock: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_flash_or_card[1] && !lvl[0]) |-> o_card_wr_locked)
        else $error("card lock not reported");
    a_card_insert: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_flash_or_card[2] && !lvl[1]) |-> o_card_inserted)
        else $error("card presence not reported");
    a_pin_dir: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        o_chip_sel1_oe_n == i_flash_or_card[1])
        else $error("shared pin direction wrong");

    c_read: cover property (@(posedge i_core_clk) $fell(o_read_strobe_n));
    c_write: cover property (@(posedge i_core_clk) $fell(o_write_strobe_n) && !card_mode3);
    c_card: cover property (@(posedge i_core_clk) !o_card_sel_n && card_mode3);
    c_stall: cover property (@(posedge i_core_clk) o_rd_valid && !i_rd_ready && !buf_ready);
endmodule

/* File: rtl/nand_pins_pkg.sv */
// Purpose: shared constants and carriers for the nand flash pin interface
// Assumes: 100 MHz core clock, one clock domain
// Notes: Contract
// Contract
// - eight-line data bus, driven writes, released reads
// - address latch high through address write only
// - command latch high through command write only
// - read strobe low only while reading
// - write strobe low only while writing
// - chip select zero low when accessing device zero
// - chip selects one to three follow selected device
// - card select low during every card access
// - card write lock low means card protected
// - card present low means card inserted
// - write protect held low during reset
package nand_pins_pkg;
    localparam int DATA_W = 8; // memory data bus width
    localparam int NUM_CS = 4; // chip enable pins
    localparam int STROBE_NS = 30; // least strobe low time
    localparam int CLK_NS = 10; // core clock period
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS; // rounded up
    localparam int SETUP_NS = 20; // least latch setup before strobe
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 4; // phase counter width
    localparam logic [1:0] TGT_CARD = 2'h3; // card target uses pin three

    // kind of one bus cycle
    typedef enum logic [1:0] {
        OP_CMD,
        OP_ADDR,
        OP_WRITE,
        OP_READ
    } op_e;

    // one request from the controller core
    typedef struct packed {
        op_e op;
        logic card; // access goes to card slot
        logic [1:0] dev; // nand device number
        logic [DATA_W-1:0] data; // write byte
    } req_s;

    // pin drive bundle
    typedef struct packed {
        logic addr_latch_en;
        logic cmd_latch_en;
        logic read_strobe_n;
        logic write_strobe_n;
        logic [NUM_CS-1:0] chip_sel_n;
    } pins_s;
endpackage

/* File: rtl/pin_sync.sv */
// Purpose: two flop synchroniser for asynchronous pin levels
// Assumes: levels only, no pulses
// Notes: first stage read only by second stage
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 2, // lanes
    parameter logic [W-1:0] INIT = '1 // idle value
) (
    input wire logic i_core_clk, // core clock
    input wire logic i_sys_rst, // sync reset, high
    input wire logic [W-1:0] i_async, // raw pin levels
    output logic [W-1:0] o_sync // synchronised levels
);
    // all state in one struct
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } st_s;
    st_s st;
    st_s next_st;

    // shift chain
    always_comb begin
        next_st = st;
        next_st.meta = i_async;
        next_st.sync = st.meta;
    end

    // register
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            st <= '{meta: INIT, sync: INIT};
        end else begin
            st <= next_st;
        end
    end

    assign o_sync = st.sync;
endmodule

/* File: rtl/skid_buf.sv */
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock
// Notes: ready in depends only on fill level, so no loop
`timescale 1ns/1ps
module skid_buf #(
    parameter int W = 8, // word width
    parameter int DEPTH = 2 // entries
) (
    input wire logic i_core_clk, // core clock
    input wire logic i_sys_rst, // sync reset, high
    input wire logic i_in_valid, // word offered
    output logic o_in_ready, // room available
    input wire logic [W-1:0] i_in_data, // word in
    output logic o_out_valid, // word held
    input wire logic i_out_ready, // sink takes word
    output logic [W-1:0] o_out_data // oldest word
);
    localparam int PW = $clog2(DEPTH);
    // all state in one struct
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } st_s;
    st_s st;
    st_s next_st;
    logic push;
    logic pop;

    // pointer and count update
    always_comb begin
        next_st = st;
        push = i_in_valid && o_in_ready;
        pop = o_out_valid && i_out_ready;
        if (push) begin
            next_st.mem[st.wp] = i_in_data;
            next_st.wp = PW'(st.wp + 1'b1);
        end
        if (pop) begin
            next_st.rp = PW'(st.rp + 1'b1);
        end
        next_st.cnt = (PW+1)'(st.cnt + push - pop);
    end

    // register
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_in_ready = (st.cnt != (PW+1)'(DEPTH));
    assign o_out_valid = (st.cnt != '0);
    assign o_out_data = st.mem[st.rp];
endmodule

/* File: test/nand_flash_pin_interface_tb_top.sv */
// Purpose: self-checking bench for the nand pin sequencer
// Assumes: inputs driven at falling edge, cycle figures from the hand-over
// Notes: table of bus cycles first, then stall, card pins and reset
`timescale 1ns/1ps
module nand_flash_pin_interface_tb_top;
    import nand_pins_pkg::*;
    typedef struct packed {
        op_e op; // kind of cycle
        logic card; // card target
        logic [1:0] dev; // device number
        logic [7:0] data; // byte written or expected
        logic [2:0] cfg; // shared pin use
    } row_s;
    logic core_clk, sys_rst, req_valid, rd_ready, wp_req, card_locked, card_in;
    logic [2:0] cfg;
    req_s req;
    logic req_ready, rd_valid, locked, inserted, busy, bus_oe_n, ale, cle, rs_n, ws_n;
    logic sel0_n, sel1_n, sel1_oe_n, sel2_n, sel2_oe_n, card_sel_n, wp_n, lock_n, present_n;
    logic [7:0] rd_data, bus_out, bus_drv, bus_w, last_cmd, last_addr, last_wr;
    logic [3:0] sel_w; // select levels on the wires
    int failures, compares, n;
    logic [7:0] rdq [$]; // read bytes handed to the core
    row_s rows [12];

    // wire levels from all drivers
    assign bus_w = bus_oe_n ? bus_drv : bus_out;
    assign sel_w = {card_sel_n, sel2_oe_n ? present_n : sel2_n,
                    sel1_oe_n ? lock_n : sel1_n, sel0_n};

    nand_flash_pin_interface dut_u (.i_core_clk(core_clk), .i_sys_rst(sys_rst),
        .i_flash_or_card(cfg), .i_wr_protect_req(wp_req), .i_req_valid(req_valid),
        .o_req_ready(req_ready), .i_req(req), .o_rd_valid(rd_valid), .i_rd_ready(rd_ready),
        .o_rd_data(rd_data), .o_card_wr_locked(locked), .o_card_inserted(inserted),
        .o_busy(busy), .i_mem_data_bus(bus_w), .o_mem_data_bus(bus_out),
        .o_mem_data_bus_oe_n(bus_oe_n), .o_addr_latch_en(ale), .o_cmd_latch_en(cle),
        .o_read_strobe_n(rs_n), .o_write_strobe_n(ws_n), .o_chip_sel0_n(sel0_n),
        .o_chip_sel1_n(sel1_n), .o_chip_sel1_oe_n(sel1_oe_n), .i_card_wr_lock_n(sel_w[1]),
        .o_chip_sel2_n(sel2_n), .o_chip_sel2_oe_n(sel2_oe_n), .i_card_present_n(sel_w[2]),
        .o_card_sel_n(card_sel_n), .o_mem_wr_protect_n(wp_n));

    nand_mem_model mem_u (.i_core_clk(core_clk), .i_sel_n(sel_w), .i_cmd_latch_en(cle),
        .i_addr_latch_en(ale), .i_read_strobe_n(rs_n), .i_write_strobe_n(ws_n),
        .i_bus(bus_w), .i_card_locked(card_locked), .i_card_in(card_in),
        .o_bus_drive(bus_drv), .o_lock_n(lock_n), .o_present_n(present_n),
        .o_last_cmd(last_cmd), .o_last_addr(last_addr), .o_last_wr(last_wr));

    ////////////////////////////////////////////////////////////////////////
    // clock, read collector, watchdog
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
            rdq.push_back(rd_data);
        end
    end
    initial begin
        #20000;
        failures++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // compare, verdict and one bus cycle
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // called at a falling edge; checks pins mid strobe and after the cycle
    task automatic send(input row_s r);
        int k;
        k = 0;
        cfg = r.cfg;
        req = '{op: r.op, card: r.card, dev: r.dev, data: r.data};
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && k < 40) begin
            @(negedge core_clk);
            k++;
        end
        @(negedge core_clk);
        req_valid = 1'b0;
        repeat (2) @(negedge core_clk);
        chk_byte({4'h0, sel_w}, {4'h0, r.card ? 4'h7 : ~(4'h1 << r.dev)});
        chk_byte({3'h0, cle, ale, rs_n, ws_n, bus_oe_n}, {3'h0, r.op == OP_CMD,
            r.op == OP_ADDR, r.op != OP_READ, r.op == OP_READ, r.op == OP_READ});
        if (r.op != OP_READ) begin
            chk_byte(bus_out, r.data);
        end
        repeat (5) @(negedge core_clk);
        chk_byte({sel_w, cle, ale, rs_n, ws_n}, 8'hf3);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rows = '{'{OP_CMD, 0, 0, 8'h80, 0}, '{OP_ADDR, 0, 0, 8'h15, 0},
                 '{OP_WRITE, 0, 0, 8'ha5, 0}, '{OP_WRITE, 0, 1, 8'h3c, 0},
                 '{OP_WRITE, 0, 2, 8'hc3, 0}, '{OP_WRITE, 0, 3, 8'h5a, 0},
                 '{OP_READ, 0, 0, 8'ha5, 0}, '{OP_READ, 0, 3, 8'h5a, 0},
                 '{OP_READ, 0, 1, 8'h3c, 0}, '{OP_READ, 0, 2, 8'hc3, 0},
                 '{OP_WRITE, 1, 2, 8'h96, 3'h7}, '{OP_READ, 1, 0, 8'h96, 3'h7}};
        sys_rst = 1'b1;
        req_valid = 1'b0;
        rd_ready = 1'b1;
        wp_req = 1'b0;
        card_locked = 1'b0;
        card_in = 1'b0;
        cfg = 3'h0;
        req = '0;
        repeat (6) @(negedge core_clk);
        chk_byte({3'h0, wp_n, sel_w}, 8'h0f);
        sys_rst = 1'b0;
        repeat (3) @(negedge core_clk);
        chk_byte({7'h0, wp_n}, 8'h01);
        foreach (rows[i]) begin
            send(rows[i]);
            n = 0;
            case (rows[i].op)
                OP_CMD: chk_byte(last_cmd, rows[i].data);
                OP_ADDR: chk_byte(last_addr, rows[i].data);
                OP_WRITE: chk_byte(last_wr, rows[i].data);
                default: begin
                    while (rdq.size() == 0 && n < 10) begin
                        @(negedge core_clk);
                        n++;
                    end
                    chk_byte(rdq.size() > 0 ? rdq.pop_front() : 8'h00, rows[i].data);
                end
            endcase
        end
        // core stalls: two reads fill the buffer, a third is refused
        rd_ready = 1'b0;
        send(rows[6]);
        send(rows[8]);
        req = '{op: OP_READ, card: 1'b0, dev: 2'h2, data: 8'h00};
        req_valid = 1'b1;
        repeat (20) @(negedge core_clk);
        chk_byte({7'h0, req_ready}, 8'h00);
        req_valid = 1'b0;
        rd_ready = 1'b1;
        repeat (5) @(negedge core_clk);
        chk_byte(rdq.size() == 2 ? rdq.pop_front() : 8'h00, 8'ha5);
        chk_byte(rdq.size() == 1 ? rdq.pop_front() : 8'h00, 8'h3c);
        // card slot pins in both uses
        cfg = 3'h7;
        card_locked = 1'b1;
        card_in = 1'b1;
        repeat (4) @(negedge core_clk);
        chk_byte({4'h0, locked, inserted, sel1_oe_n, sel2_oe_n}, 8'h0f);
        card_locked = 1'b0;
        card_in = 1'b0;
        repeat (4) @(negedge core_clk);
        chk_byte({4'h0, locked, inserted, sel1_oe_n, sel2_oe_n}, 8'h03);
        cfg = 3'h0;
        card_locked = 1'b1;
        card_in = 1'b1;
        repeat (4) @(negedge core_clk);
        chk_byte({4'h0, locked, inserted, sel1_oe_n, sel2_oe_n}, 8'h00);
        // write protect by request, then by a second reset
        wp_req = 1'b1;
        repeat (2) @(negedge core_clk);
        chk_byte({7'h0, wp_n}, 8'h00);
        wp_req = 1'b0;
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        chk_byte({3'h0, wp_n, sel_w}, 8'h0f);
        sys_rst = 1'b0;
        repeat (3) @(negedge core_clk);
        chk_byte({7'h0, wp_n}, 8'h01);
        finish_test();
    end
endmodule

/* File: test/nand_mem_model.sv */
// Purpose: behavioural nand devices and card slot on the far side of the pins
// Assumes: one byte store per select pin, strobes registered by the controller
// Notes: released bus shows a value that flips every cycle
`timescale 1ns/1ps
module nand_mem_model (
    input wire logic i_core_clk, // core clock
    input wire logic [3:0] i_sel_n, // select levels as seen on the wires
    input wire logic i_cmd_latch_en, // command latch
    input wire logic i_addr_latch_en, // address latch
    input wire logic i_read_strobe_n, // read strobe
    input wire logic i_write_strobe_n, // write strobe
    input wire logic [7:0] i_bus, // resolved data bus
    input wire logic i_card_locked, // card lock tab set
    input wire logic i_card_in, // card in the slot
    output logic [7:0] o_bus_drive, // level the devices offer
    output logic o_lock_n, // lock pin, pulled up
    output logic o_present_n, // presence pin, pulled up
    output logic [7:0] o_last_cmd, // last command byte taken
    output logic [7:0] o_last_addr, // last address byte taken
    output logic [7:0] o_last_wr // last data byte taken
);
    logic [7:0] mem [4]; // one byte per target, pin three shared with card
    logic [7:0] last = 8'h00; // last bus level, for the released pattern
    logic hit; // exactly one target selected
    logic [1:0] tgt; // selected target

    ////////////////////////////////////////////////////////////////////////
    // decode which device or the card is selected
    always_comb begin
        hit = ($countones(~i_sel_n) == 1);
        tgt = 2'h0;
        for (int k = 0; k < 4; k++) begin
            if (i_sel_n[k] == 1'b0) begin
                tgt = 2'(k);
            end
        end
    end

    // byte taken when the write strobe rises
    always @(posedge i_write_strobe_n) begin
        if (hit === 1'b1) begin
            if (i_cmd_latch_en) begin
                o_last_cmd <= i_bus;
            end else if (i_addr_latch_en) begin
                o_last_addr <= i_bus;
            end else begin
                o_last_wr <= i_bus;
                mem[tgt] <= i_bus;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // drive stored byte while read strobe low, else a changing pattern
    always @(posedge i_core_clk) begin
        last <= o_bus_drive;
    end
    assign o_bus_drive = (hit && !i_read_strobe_n) ? mem[tgt] : ~last;
    assign o_lock_n = ~i_card_locked;
    assign o_present_n = ~i_card_in;
endmodule
